// file: rtl/itm_cfg.sv
// Second interrupt pin map, rate and synchronisation control, and measurement control bank
`timescale 1ns/1ps
`include "itm_cfg_regs.svh"

// Summary of operation
// (R1) Pin map bit 7 set makes the second interrupt pin active low.
// (R2) Pin map bit 6 routes the awake condition to the second pin.
// (R3) Pin map bit 5 routes the second motion condition to the second pin.
// (R4) Pin map bit 4 routes the stillness condition to the second pin.
// (R5) Pin map bit 0 routes sample valid; bits 3..1 reserved, read zero.
// (R6) All mapped conditions are ORed to form the pin state.
// (R7) With nothing mapped the pin is released, not driven.
// (R8) Rate bits 7..5 select sample rate 320 Hz doubling to 5120 Hz.
// (R9) Rate bits 4..2 select wake timer 65 ms up to 30720 ms.
// (R10) Rate bit 1 enables outside clock, bit 0 outside trigger.
// (R11) Autosleep bit 6 enters wake mode once stillness is detected.
// (R12) Autosleep is ignored unless linked or looped chaining is active.
// (R13) Chain code 00: both detectors run, host acknowledges by status read.
// (R14) Chain code 01: detectors alternate, host acknowledges by status read.
// (R15) Chain code 10: detectors alternate, acknowledged internally.
// (R16) Linked or looped needs both detect enables, else default mode.
// (R17) Low-noise bit clear is normal, set is low-noise operation.
// (R18) Measurement bits 2..0 select filter corner 160 Hz up to 2560 Hz.
// (R19) Low-noise select sits at measurement bit 3.
// (R20) Host must not write codes 101..111 to rate or bandwidth fields.
module itm_cfg
#(
  parameter int ODR_BASE_CYC = `ITM_ODR_BASE_CYC, // Cycles per sample at the slowest rate
  parameter int CYC_PER_MS = `ITM_CYC_PER_MS // Cycles per millisecond of the wake timer
)
(
  input wire logic clk, // Core clock, 200 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire itm_pkg::itm_reg_req_t reg_req, // Register access strobes from the serial port
  output logic [7:0] rd_data_q, // Read data
  output logic rd_valid_q, // Read data valid pulse
  input wire itm_pkg::itm_irq_src_t irq_src, // Interrupt conditions
  input wire logic motion_evt, // Motion detected pulse
  input wire logic stillness_evt, // Stillness detected pulse
  input wire logic status_read, // Host read of the status register
  input wire logic motion_detect_enable, // Motion detector enabled
  input wire logic stillness_detect_enable, // Stillness detector enabled
  input wire logic outside_clock_pin, // Outside clock pin
  input wire logic outside_trigger_pin, // Outside trigger pin
  output logic second_irq_pin_o, // Pin output level
  output logic second_irq_pin_oe, // Pin output enable, high while driven
  output logic sample_tick_q, // Sample strobe at the selected rate
  output logic wake_tick_q, // Wake timer expiry pulse
  output logic wake_mode_q, // Device sits in wake mode
  output logic motion_arm_q, // Motion detector armed
  output logic stillness_arm_q, // Stillness detector armed
  output logic irq_ack_q, // Internal acknowledge pulse of a detection
  output logic low_noise_q, // Low-noise operation selected
  output logic [2:0] lpf_corner_q, // Filter corner code
  output logic overrange_dis_q // Overrange disable
);
  import itm_pkg::*;

  // The fastest code divides the base by 16 and must still leave four cycles per sample
  if (ODR_BASE_CYC < 64 || CYC_PER_MS < 2)
  begin : g_bad_param
    $error("itm_cfg: timing parameters too small");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] map_q;
  logic [7:0] rate_q;
  logic [7:0] meas_q;
  logic hit_map;
  logic hit_rate;
  logic hit_meas;
  logic [7:0] rd_mux;

  // Address decode
  assign hit_map = reg_req.addr == `ITM_ADDR_PIN_MAP;
  assign hit_rate = reg_req.addr == `ITM_ADDR_RATE;
  assign hit_meas = reg_req.addr == `ITM_ADDR_MEASUREMENT_CONTROL;
  // Unmapped addresses read as zero; reserved map bits read as zero
  assign rd_mux = hit_map ? map_q : (hit_rate ? rate_q : (hit_meas ? meas_q : 8'h00)); // R5

  // Writes land one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      map_q <= `ITM_RST_PIN_MAP;
      rate_q <= `ITM_RST_RATE;
      meas_q <= `ITM_RST_MEASUREMENT_CONTROL;
    end
    else if (reg_req.wr)
    begin
      if (hit_map)
        map_q <= reg_req.wdata & `ITM_PIN_MAP_WMASK; // R5
      if (hit_rate)
        rate_q <= reg_req.wdata;
      if (hit_meas)
        meas_q <= reg_req.wdata;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q <= reg_req.rd ? rd_mux : rd_data_q;
      rd_valid_q <= reg_req.rd;
    end
  end

  // ----------------------------------------------------------------
  // Second interrupt pin
  // ----------------------------------------------------------------
  logic [3:0] map_sel;
  logic [3:0] src_vec;
  logic pin_any;
  logic pin_mapped;

  assign map_sel = {map_q[`ITM_MAP_AWAKE], map_q[`ITM_MAP_MOTION_B], // R2 R3
    map_q[`ITM_MAP_STILL], map_q[`ITM_MAP_SVALID]}; // R4 R5
  assign src_vec = {irq_src.awake, irq_src.motion_b, irq_src.stillness, irq_src.sample_valid};
  assign pin_any = |(map_sel & src_vec); // R6
  assign pin_mapped = |map_sel; // R7

  // Registered pin drive; release when nothing is mapped so a shared line stays free
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      second_irq_pin_o <= 1'b0;
      second_irq_pin_oe <= 1'b0;
    end
    else
    begin
      second_irq_pin_o <= pin_any ^ map_q[`ITM_MAP_POL_LOW]; // R1
      second_irq_pin_oe <= pin_mapped; // R7
    end
  end

  // ----------------------------------------------------------------
  // Outside clock and trigger pins
  // ----------------------------------------------------------------
  logic outside_clock_enable_rise;
  logic ext_trig_rise;
  logic use_outside_clock_enable;
  logic use_ext_trig;

  itm_sync3 u_sync_clk
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(outside_clock_pin),
    .level_q(),
    .rise_q(outside_clock_enable_rise)
  );

  itm_sync3 u_sync_trig
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(outside_trigger_pin),
    .level_q(),
    .rise_q(ext_trig_rise)
  );

  assign use_outside_clock_enable = rate_q[`ITM_RATE_OUTSIDE_CLOCK_ENABLE]; // R10
  assign use_ext_trig = rate_q[`ITM_RATE_EXT_TRIG]; // R10

  // ----------------------------------------------------------------
  // Sample rate
  // ----------------------------------------------------------------
  logic [2:0] odr_code;
  logic [31:0] odr_period;
  logic time_adv;
  logic odr_tick;

  // Undefined codes are clamped to the fastest rate rather than running wild
  assign odr_code = (rate_q[`ITM_RATE_ODR_HI:`ITM_RATE_ODR_LO] > `ITM_ODR_MAX_CODE)
    ? `ITM_ODR_MAX_CODE : rate_q[`ITM_RATE_ODR_HI:`ITM_RATE_ODR_LO]; // R8
  assign odr_period = 32'(ODR_BASE_CYC) >> odr_code; // R8
  // On the outside clock every timebase steps once per filtered edge
  assign time_adv = use_outside_clock_enable ? outside_clock_enable_rise : 1'b1; // R10

  itm_tick_gen #(.CNT_W(32)) u_odr
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(1'b0),
    .adv(time_adv),
    .period(odr_period),
    .tick_q(odr_tick)
  );

  // Outside trigger replaces the internal rate as sample strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sample_tick_q <= 1'b0;
    else
      sample_tick_q <= use_ext_trig ? ext_trig_rise : odr_tick; // R10
  end

  // ----------------------------------------------------------------
  // Wake timer
  // ----------------------------------------------------------------
  logic [15:0] wake_ms;
  logic ms_tick;
  logic wake_tick;

  // Period table in milliseconds
  always_comb
  begin
    unique case (rate_q[`ITM_RATE_WAKE_HI:`ITM_RATE_WAKE_LO]) // R9
      3'h0: wake_ms = `ITM_WAKE_MS_0;
      3'h1: wake_ms = `ITM_WAKE_MS_1;
      3'h2: wake_ms = `ITM_WAKE_MS_2;
      3'h3: wake_ms = `ITM_WAKE_MS_3;
      3'h4: wake_ms = `ITM_WAKE_MS_4;
      3'h5: wake_ms = `ITM_WAKE_MS_5;
      3'h6: wake_ms = `ITM_WAKE_MS_6;
      3'h7: wake_ms = `ITM_WAKE_MS_7;
    endcase
  end

  // Millisecond prescaler, then the period counter; both idle outside wake mode
  itm_tick_gen #(.CNT_W(32)) u_ms
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!wake_mode_q),
    .adv(time_adv),
    .period(32'(CYC_PER_MS)),
    .tick_q(ms_tick)
  );

  itm_tick_gen #(.CNT_W(16)) u_wake
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!wake_mode_q),
    .adv(ms_tick),
    .period(wake_ms),
    .tick_q(wake_tick)
  );

  // ----------------------------------------------------------------
  // Motion and stillness chaining
  // ----------------------------------------------------------------
  itm_chain_t chain_mode;
  logic chain_ok;
  logic chained;
  logic looped;
  itm_watch_t watch_q;
  itm_watch_t watch_d;
  logic ack_d;
  logic sleep_en;

  assign chain_mode = itm_chain_t'(meas_q[`ITM_MEAS_CHAIN_HI:`ITM_MEAS_CHAIN_LO]);
  assign chain_ok = motion_detect_enable && stillness_detect_enable; // R16
  // Undefined code 11 behaves as the default mode
  assign chained = chain_ok && (chain_mode == ITM_CHAIN_LINKED || chain_mode == ITM_CHAIN_LOOPED); // R16
  assign looped = chained && (chain_mode == ITM_CHAIN_LOOPED); // R15
  assign sleep_en = meas_q[`ITM_MEAS_AUTOSLEEP] && chained; // R12

  // Alternate the armed detector; default mode keeps every enabled detector armed
  always_comb
  begin
    watch_d = watch_q;
    ack_d = 1'b0;
    if (!chained)
      watch_d = ITM_WATCH_BOTH; // R13
    else
    begin
      unique case (watch_q)
        ITM_WATCH_BOTH: watch_d = ITM_WATCH_MOTION; // R14
        ITM_WATCH_MOTION:
        begin
          if (motion_evt)
          begin
            watch_d = ITM_WATCH_STILL; // R14
            ack_d = looped; // R15
          end
        end
        ITM_WATCH_STILL:
        begin
          if (stillness_evt)
          begin
            watch_d = ITM_WATCH_MOTION; // R14
            ack_d = looped; // R15
          end
        end
      endcase
    end
  end

  // State and detector arms; host acknowledges through the status read outside this bank
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      watch_q <= ITM_WATCH_BOTH;
      motion_arm_q <= 1'b0;
      stillness_arm_q <= 1'b0;
      irq_ack_q <= 1'b0;
    end
    else
    begin
      watch_q <= watch_d;
      motion_arm_q <= motion_detect_enable && (watch_d != ITM_WATCH_STILL); // R13 R14
      stillness_arm_q <= stillness_detect_enable && (watch_d != ITM_WATCH_MOTION); // R13 R14
      irq_ack_q <= ack_d; // R15
    end
  end

  // Autosleep: enter wake mode on stillness, leave on motion; the set wins a clash
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wake_mode_q <= 1'b0;
      wake_tick_q <= 1'b0;
    end
    else
    begin
      if (sleep_en && stillness_evt)
        wake_mode_q <= 1'b1; // R11
      else if (motion_evt || !sleep_en)
        wake_mode_q <= 1'b0; // R12
      wake_tick_q <= wake_tick && wake_mode_q; // R9
    end
  end

  // ----------------------------------------------------------------
  // Measurement controls
  // ----------------------------------------------------------------
  // Undefined bandwidth codes clamp to the widest corner
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      low_noise_q <= 1'b0;
      lpf_corner_q <= 3'h0;
      overrange_dis_q <= 1'b0;
    end
    else
    begin
      low_noise_q <= meas_q[`ITM_MEAS_LOW_NOISE]; // R17 R19
      lpf_corner_q <= (meas_q[`ITM_MEAS_BW_HI:`ITM_MEAS_BW_LO] > `ITM_BW_MAX_CODE)
        ? `ITM_BW_MAX_CODE : meas_q[`ITM_MEAS_BW_HI:`ITM_MEAS_BW_LO]; // R18
      overrange_dis_q <= meas_q[`ITM_MEAS_OVR_DIS];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_POL_LOW: assert property (map_q[7] && map_q[6] && irq_src.awake |=> !second_irq_pin_o) // R1
    else $error("active low pin not low with awake mapped");
  AST_AWAKE_ROUTE: assert property (!map_q[7] && map_q[6] && irq_src.awake |=> second_irq_pin_o) // R2
    else $error("awake condition not routed");
  AST_OR_COMBINE: assert property (!map_q[7] && (map_q[5] && irq_src.motion_b || map_q[4] && irq_src.stillness
    || map_q[0] && irq_src.sample_valid) |=> second_irq_pin_o) // R6
    else $error("mapped condition missing from pin");
  AST_RELEASE: assert property ((map_q[6:4] == 3'h0) && !map_q[0] |=> !second_irq_pin_oe) // R7
    else $error("pin driven with nothing mapped");
  AST_RSVD_ZERO: assert property (reg_req.rd && hit_map |=> rd_valid_q && rd_data_q[3:1] == 3'h0) // R5
    else $error("reserved map bits not zero");
  AST_ODR_PERIOD: assert property ($rose(odr_tick) && !use_outside_clock_enable && $stable(rate_q) |=> !odr_tick [*3]) // R8
    else $error("sample rate tick too frequent");
  AST_FALLBACK: assert property (!chain_ok |=> watch_q == ITM_WATCH_BOTH) // R16
    else $error("chaining active without both enables");
  AST_LOOP_ACK: assert property (looped && watch_q == ITM_WATCH_MOTION && motion_evt |=> irq_ack_q) // R15
    else $error("looped mode did not acknowledge");
  AST_LINK_NOACK: assert property (!looped |=> !irq_ack_q) // R14
    else $error("internal acknowledge outside looped mode");
  AST_SLEEP_IGNORED: assert property (!sleep_en |=> !wake_mode_q) // R12
    else $error("wake mode entered while autosleep ignored");
  AST_SLEEP_ENTER: assert property (sleep_en && stillness_evt |=> wake_mode_q) // R11
    else $error("autosleep did not enter wake mode");
  AST_LOW_NOISE: assert property (low_noise_q == $past(meas_q[3]) && lpf_corner_q <= 3'h4) // R17
    else $error("measurement outputs wrong");

  COV_LOOPED: cover property (looped && motion_evt ##[1:50] stillness_evt);
  COV_PIN_LOW: cover property (second_irq_pin_oe && map_q[7] && !second_irq_pin_o);
  COV_WAKE: cover property (wake_mode_q ##1 wake_tick_q);
  COV_EXT_TRIG: cover property (use_ext_trig && sample_tick_q);
endmodule

// file: rtl/itm_cfg_regs.svh
// Register offsets, field positions, reset values and timing counts of the configuration bank
`ifndef ITM_CFG_REGS_SVH
`define ITM_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define ITM_ADDR_PIN_MAP 8'h3C
`define ITM_ADDR_RATE 8'h3D
`define ITM_ADDR_MEASUREMENT_CONTROL 8'h3E
`define ITM_RST_PIN_MAP 8'h00
`define ITM_RST_RATE 8'h00
`define ITM_RST_MEASUREMENT_CONTROL 8'h00
// Writable bits of the pin map; bits 3..1 are reserved and read as zero
`define ITM_PIN_MAP_WMASK 8'hF1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ITM_MAP_POL_LOW 7
`define ITM_MAP_AWAKE 6
`define ITM_MAP_MOTION_B 5
`define ITM_MAP_STILL 4
`define ITM_MAP_SVALID 0
`define ITM_RATE_ODR_HI 7
`define ITM_RATE_ODR_LO 5
`define ITM_RATE_WAKE_HI 4
`define ITM_RATE_WAKE_LO 2
`define ITM_RATE_OUTSIDE_CLOCK_ENABLE 1
`define ITM_RATE_EXT_TRIG 0
`define ITM_MEAS_OVR_DIS 7
`define ITM_MEAS_AUTOSLEEP 6
`define ITM_MEAS_CHAIN_HI 5
`define ITM_MEAS_CHAIN_LO 4
`define ITM_MEAS_LOW_NOISE 3
`define ITM_MEAS_BW_HI 2
`define ITM_MEAS_BW_LO 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ITM_CLK_HZ 200000000
`define ITM_ODR_BASE_HZ 320
`define ITM_ODR_MAX_CODE 3'h4
`define ITM_BW_MAX_CODE 3'h4
`define ITM_ODR_BASE_CYC (`ITM_CLK_HZ / `ITM_ODR_BASE_HZ)
`define ITM_MS_PER_S 1000
`define ITM_CYC_PER_MS (`ITM_CLK_HZ / `ITM_MS_PER_S)
`define ITM_WAKE_MS_0 16'd65
`define ITM_WAKE_MS_1 16'd130
`define ITM_WAKE_MS_2 16'd260
`define ITM_WAKE_MS_3 16'd640
`define ITM_WAKE_MS_4 16'd2560
`define ITM_WAKE_MS_5 16'd5120
`define ITM_WAKE_MS_6 16'd10240
`define ITM_WAKE_MS_7 16'd30720

`endif

// file: rtl/itm_pkg.sv
// Types shared by the configuration bank and its helpers
package itm_pkg;

  // Register access from the serial port front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } itm_reg_req_t;

  // Interrupt conditions from the status logic, all levels
  typedef struct packed {
    logic awake;
    logic motion_b;
    logic stillness;
    logic sample_valid;
  } itm_irq_src_t;

  // Chaining of motion and stillness detection
  typedef enum logic [1:0] {
    ITM_CHAIN_DEFAULT = 2'h0,
    ITM_CHAIN_LINKED = 2'h1,
    ITM_CHAIN_LOOPED = 2'h2,
    ITM_CHAIN_UNDEF = 2'h3
  } itm_chain_t;

  // Which detector is armed
  typedef enum logic [1:0] {
    ITM_WATCH_BOTH,
    ITM_WATCH_MOTION,
    ITM_WATCH_STILL
  } itm_watch_t;

endpackage

// file: rtl/itm_sync3.sv
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module itm_sync3
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic async_in, // Pin level from outside the clock domain
  output logic level_q, // Filtered level
  output logic rise_q // One-cycle pulse on a filtered rising edge
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Stage one is read by stage two only, to keep metastability contained
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end
endmodule

// file: rtl/itm_tick_gen.sv
// Programmable period counter that emits one tick per period of advance strobes
`timescale 1ns/1ps
module itm_tick_gen
#(
  parameter int CNT_W = 32 // Counter width
)
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clear, // Restart the period
  input wire logic adv, // Count one step
  input wire logic [CNT_W-1:0] period, // Steps per tick, zero treated as one
  output logic tick_q // One-cycle pulse at the end of a period
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  logic wrap;

  if (CNT_W < 2)
  begin : g_bad_width
    $error("itm_tick_gen: CNT_W must be at least 2");
  end

  // Terminal count; a zero period must not stall the counter
  assign last = (period == '0) ? '0 : period - CNT_W'(1);
  assign wrap = adv && (cnt_q >= last);

  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap ? '0 : (adv ? cnt_q + CNT_W'(1) : cnt_q);
      tick_q <= wrap;
    end
  end
endmodule

// file: test/itm_host_model.sv
// Host model of the register port: single byte writes and reads
`timescale 1ns/1ps
`include "itm_cfg_regs.svh"
module itm_host_model
(
  input wire logic clk, // Core clock
  output itm_pkg::itm_reg_req_t req, // Strobes to the bank
  input wire logic [7:0] rd_data_q, // Read data
  input wire logic rd_valid_q // Read data valid
);
  import itm_pkg::*;
  initial req = '0;
  // Write strobe stands for exactly one edge; address released to its inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    begin
      v = d;
      // Undefined rate and corner codes are never sent
      if (a == `ITM_ADDR_RATE && v[7:5] > 3'h4) v[7:5] = 3'h4;
      if (a == `ITM_ADDR_MEASUREMENT_CONTROL && v[2:0] > 3'h4) v[2:0] = 3'h4;
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= v;
      @(posedge clk);
      req.wr <= 1'b0;
      req.addr <= ~a;
      req.wdata <= ~v;
    end
  endtask
  // Read: valid is looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    begin
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      req.addr <= ~a;
      #1;
      ok = rd_valid_q;
      d = rd_data_q;
    end
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench of the configuration bank
`timescale 1ns/1ps
`include "itm_cfg_regs.svh"
module testbench;
  import itm_pkg::*;
  localparam int ODR_CYC = 64;
  logic clk, rst_n, me, se, mev, sev, tpin, cpin;
  itm_reg_req_t req;
  itm_irq_src_t src;
  logic [7:0] rdq, d;
  logic rv, po, poe, tick, wtk, wake, marm, sarm, ack, lown, ovr, ok;
  logic [2:0] bw;
  int n_mismatch, n_checks, cnt;
  itm_cfg #(.ODR_BASE_CYC(ODR_CYC), .CYC_PER_MS(4)) uut (.clk(clk), .rst_n(rst_n),
    .reg_req(req), .rd_data_q(rdq), .rd_valid_q(rv), .irq_src(src), .motion_evt(mev),
    .stillness_evt(sev), .status_read(1'b0), .motion_detect_enable(me),
    .stillness_detect_enable(se), .outside_clock_pin(cpin), .outside_trigger_pin(tpin),
    .second_irq_pin_o(po), .second_irq_pin_oe(poe), .sample_tick_q(tick), .wake_tick_q(wtk),
    .wake_mode_q(wake), .motion_arm_q(marm), .stillness_arm_q(sarm), .irq_ack_q(ack),
    .low_noise_q(lown), .lpf_corner_q(bw), .overrange_dis_q(ovr));
  itm_host_model host (.clk(clk), .req(req), .rd_data_q(rdq), .rd_valid_q(rv));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    begin
      host.rd(a, d, ok);
      chk(ok, 1'b1);
      chk(d, exp);
    end
  endtask
  // Pin answers one cycle after its inputs; level only matters while driven
  task automatic pin(input logic [7:0] m, input logic [3:0] s, input logic eoe, input logic eo);
    begin
      host.wr(`ITM_ADDR_PIN_MAP, m);
      @(posedge clk);
      src <= s;
      repeat (2) @(posedge clk);
      #1;
      chk(poe, eoe);
      if (eoe) chk(po, eo);
    end
  endtask
  // Detection pulses are one cycle wide
  task automatic ev(input logic m, input logic s);
    begin
      @(posedge clk);
      mev <= m;
      sev <= s;
      @(posedge clk);
      mev <= 1'b0;
      sev <= 1'b0;
      #1;
    end
  endtask
  task automatic meas(input logic [7:0] v);
    begin
      host.wr(`ITM_ADDR_MEASUREMENT_CONTROL, v);
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Counts sample strobes, or wake timer pulses when wsel is set
  task automatic count_ticks(input int n, input logic wsel);
    begin
      cnt = 0;
      repeat (n)
      begin
        @(posedge clk);
        #1;
        cnt += wsel ? wtk : tick;
      end
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, me, se, mev, sev, tpin, cpin} = '0;
    src = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`ITM_ADDR_PIN_MAP, `ITM_RST_PIN_MAP);
    rdchk(`ITM_ADDR_RATE, `ITM_RST_RATE);
    rdchk(`ITM_ADDR_MEASUREMENT_CONTROL, `ITM_RST_MEASUREMENT_CONTROL);
    rdchk(8'h3F, 8'h00);
    host.wr(`ITM_ADDR_PIN_MAP, 8'hFF);
    rdchk(`ITM_ADDR_PIN_MAP, 8'hF1);
    host.wr(`ITM_ADDR_RATE, 8'h9E);
    rdchk(`ITM_ADDR_RATE, 8'h9E);
    host.wr(`ITM_ADDR_MEASUREMENT_CONTROL, 8'hAC);
    rdchk(`ITM_ADDR_MEASUREMENT_CONTROL, 8'hAC);
    chk(lown, 1'b1);
    chk(ovr, 1'b1);
    for (int c = 0; c < 5; c++)
    begin
      host.wr(`ITM_ADDR_MEASUREMENT_CONTROL, 8'h00 | c[2:0]);
      rdchk(`ITM_ADDR_MEASUREMENT_CONTROL, 8'h00 | c[2:0]);
      chk(bw, c[2:0]);
      chk(lown, 1'b0);
    end
    $display("register test done");
    pin(8'h40, 4'h8, 1'b1, 1'b1);
    pin(8'hC0, 4'h8, 1'b1, 1'b0);
    pin(8'hE0, 4'h0, 1'b1, 1'b1);
    pin(8'h20, 4'h4, 1'b1, 1'b1);
    pin(8'h10, 4'h2, 1'b1, 1'b1);
    pin(8'h01, 4'h1, 1'b1, 1'b1);
    pin(8'h51, 4'h1, 1'b1, 1'b1);
    pin(8'h51, 4'h0, 1'b1, 1'b0);
    pin(8'h80, 4'hF, 1'b0, 1'b0);
    $display("pin test done");
    me <= 1'b1;
    meas(8'h10);
    chk({marm, sarm}, 2'h1 << 1);
    ev(1'b1, 1'b0);
    chk(ack, 1'b0);
    meas(8'h20);
    chk({marm, sarm}, 2'h2);
    se <= 1'b1;
    meas(8'h00);
    chk({marm, sarm}, 2'h3);
    meas(8'h20);
    chk({marm, sarm}, 2'h2);
    ev(1'b1, 1'b0);
    chk({ack, marm, sarm}, 3'h5);
    ev(1'b0, 1'b1);
    chk({ack, marm, sarm}, 3'h6);
    host.wr(`ITM_ADDR_RATE, 8'h00);
    meas(8'h50);
    ev(1'b0, 1'b1);
    chk(wake, 1'b1);
    // Code 0 wake period is 65 ms, 260 cycles at four cycles per millisecond
    count_ticks(270, 1'b1);
    chk(cnt[7:0], 8'h01);
    count_ticks(260, 1'b1);
    chk(cnt[7:0], 8'h01);
    ev(1'b1, 1'b0);
    chk(wake, 1'b0);
    meas(8'h40);
    ev(1'b0, 1'b1);
    chk(wake, 1'b0);
    meas(8'h10);
    ev(1'b1, 1'b0);
    chk({ack, marm, sarm}, 3'h1);
    $display("chain test done");
    for (int c = 0; c < 5; c++)
    begin
      host.wr(`ITM_ADDR_RATE, {c[2:0], 5'h00});
      repeat (80) @(posedge clk);
      count_ticks(ODR_CYC, 1'b0);
      chk(cnt[7:0], 8'h01 << c);
    end
    host.wr(`ITM_ADDR_RATE, 8'h01);
    repeat (80) @(posedge clk);
    count_ticks(ODR_CYC, 1'b0);
    chk(cnt[7:0], 8'h00);
    tpin <= 1'b1;
    count_ticks(16, 1'b0);
    chk(cnt[7:0], 8'h01);
    // Outside clock at code 4: four filtered edges per sample, none while the pin rests
    host.wr(`ITM_ADDR_RATE, 8'h82);
    repeat (2) @(posedge clk);
    count_ticks(40, 1'b0);
    chk(cnt[7:0], 8'h00);
    cnt = 0;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk);
      cpin <= i[2] && (i < 64);
      #1;
      cnt += tick;
    end
    chk(cnt[7:0], 8'h02);
    $display("rate test done");
    end_of_test();
  end
endmodule
